// File: inc/error_encoder_pkg.sv
// Shared types and constants of the channel error-control encoder.
// Assumes a single clock domain; all users reference names by package scope.
package error_encoder_pkg;
  // Block geometry
  localparam int MAX_K1     = 288;
  localparam int LEN_W      = 9;
  localparam int IDX_W      = 10;
  localparam int CNT_W      = 11;
  localparam int CRC_LEN    = 16;
  localparam int TAIL_LEN   = 4;
  localparam int RM_K       = 14;
  localparam int FIFO_DEPTH = 4;
  // Cyclic code: low terms of X^16+X^12+X^5+1, register preset
  localparam logic [15:0] CRC_POLY   = 16'h1021;
  localparam logic [15:0] CRC_PRESET = 16'hFFFF;
  // Mother code taps as {D4,D3,D2,D1,D0}, generator one first
  localparam logic [3:0][4:0] GEN_TAPS = {5'h1B, 5'h17, 5'h1D, 5'h13};
  // Puncturing masks over the eight mother bits of one period
  localparam logic [7:0] MASK_2_3 = 8'h13;
  localparam logic [7:0] MASK_1_3 = 8'h77;
  // Index gap periods and fixed output length of the long rates
  localparam logic [6:0]       SKIP_292 = 7'h42;
  localparam logic [6:0]       SKIP_148 = 7'h24;
  localparam logic [CNT_W-1:0] K3_LONG  = 11'h1B0;
  // Parity rows of the shortened RM generator; row r belongs to info bit r+1
  localparam logic [RM_K-1:0][15:0] RM_ROWS_DEFAULT = '0;

  typedef enum logic [1:0] {
    CODE_NONE = 2'b00,
    CODE_CRC  = 2'b01,
    CODE_RM   = 2'b10
  } code_t;

  typedef enum logic [2:0] {
    RATE_UNCODED = 3'b000,
    RATE_2_3     = 3'b001,
    RATE_1_3     = 3'b010,
    RATE_292_432 = 3'b011,
    RATE_148_432 = 3'b100
  } rate_t;

  typedef enum logic [2:0] {
    KIND_CONTROL = 3'b000,
    KIND_BCAST   = 3'b001,
    KIND_SYNC    = 3'b010,
    KIND_HALF1   = 3'b011,
    KIND_HALF2   = 3'b100
  } kind_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CRC  = 2'b01,
    ST_ENC  = 2'b10
  } state_t;

  typedef struct packed {
    code_t code;
    logic  tail_en;
    rate_t rate;
    kind_t kind;
  } cfg_t;

  // Bit b1(k) sits at data[k-1]
  typedef struct packed {
    cfg_t              cfg;
    logic [LEN_W-1:0]  len;
    logic [MAX_K1-1:0] data;
  } block_t;

  typedef struct packed {
    logic  value;
    logic  last;
    kind_t kind;
  } coded_bit_t;
endpackage

// File: hdl/coded_bit_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module coded_bit_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  // Fill side
  input  wire logic             wr_valid_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output logic                  wr_ready_out,
  // Drain side
  output logic                  rd_valid_out,
  output logic [WIDTH-1:0]      rd_data_out,
  input  wire logic             rd_ready_in
);
  localparam int PW = $clog2(DEPTH);

  logic [DEPTH-1:0][WIDTH-1:0] mem, next_mem;
  logic [PW-1:0]               wptr, next_wptr, rptr, next_rptr;
  logic [PW:0]                 count, next_count;
  logic                        push, pop;

  // Handshakes and read port
  assign wr_ready_out = (count != (PW+1)'(DEPTH));
  assign rd_valid_out = (count != '0);
  assign rd_data_out  = mem[rptr];
  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = rd_valid_out && rd_ready_in;

  // Pointer and storage update
  always_comb begin
    next_mem   = mem;
    next_wptr  = wptr;
    next_rptr  = rptr;
    next_count = count;
    if (push) begin
      next_mem[wptr] = wr_data_in;
      next_wptr      = (wptr == PW'(DEPTH-1)) ? '0 : wptr + 1'b1;
    end
    if (pop) begin
      next_rptr = (rptr == PW'(DEPTH-1)) ? '0 : rptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      mem   <= '0;
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      mem   <= next_mem;
      wptr  <= next_wptr;
      rptr  <= next_rptr;
      count <= next_count;
    end
  end
endmodule

// File: hdl/channel_error_encoder.sv
// Transmit error-control encoder for one logical channel: block code,
// tail, mother convolutional code and puncturing, bit-serial output.
// Assumes the source holds a whole block on its input while valid and
// that interleaving and scrambling follow downstream.
//
// Overview of operation
// - Per-block configuration picks code, tail, rate
// - Block code, then convolutional code, fixed order
// - Optional zero tail after block-encoded bits
// - Each block encoded alone, no carried state
// - Output tagged with one of five kinds
// - Rate one-quarter mother code, then puncturing
// - Four bits per input, register cleared per block
// - Four fixed generator polynomials, modulo-two sums
// - Period of eight mother bits, t coefficients
// - Rate 2/3 keeps positions 1, 2, 5
// - Rate 1/3 keeps positions 1,2,3,5,6,7
// - Rate 292/432 skips every 66th index
// - Rate 148/432 skips every 36th index
// - Systematic (30,14) RM code via generator
// - First information bit is highest-degree coefficient
// - Preset remainder, then inverted sixteen parity bits
// - Information bits, then parity f(15) down to f(0)
`timescale 1ns/1ps
module channel_error_encoder #(
  parameter logic [error_encoder_pkg::RM_K-1:0][15:0] RM_ROWS =
    error_encoder_pkg::RM_ROWS_DEFAULT
) (
  // Clock and reset
  input  wire logic                          clk_in,
  input  wire logic                          sys_rst_in,
  // Type-1 block from the MAC source
  input  wire logic                          blk_valid_in,
  input  wire error_encoder_pkg::block_t     blk_in,
  output logic                               blk_ready_out,
  // Coded bit stream toward the interleaver
  output logic                               bit_valid_out,
  output error_encoder_pkg::coded_bit_t      bit_out,
  input  wire logic                          bit_ready_in,
  // Status
  output logic                               busy_out
);
  localparam int IW = error_encoder_pkg::IDX_W;
  localparam int CW = error_encoder_pkg::CNT_W;

  error_encoder_pkg::state_t     state, next_state;
  error_encoder_pkg::block_t     blk, next_blk;
  logic [15:0]                   crc, next_crc;
  logic [3:0]                    sr, next_sr;
  logic [IW-1:0]                 k2, next_k2;
  logic [1:0]                    g, next_g;
  logic [CW-1:0]                 nout, next_nout;
  logic [6:0]                    skip_cnt, next_skip_cnt;

  logic [IW-1:0]                 k1, k2_len;
  logic [CW-1:0]                 k3_len;
  logic [7:0]                    mask;
  logic [6:0]                    period;
  logic                          coded, cur, mbit, sel, skip, emit;
  logic                          push_ready;
  error_encoder_pkg::coded_bit_t push_data;

  // RM parity as a sum of selected generator rows
  function automatic logic [15:0] rm_parity(input logic [error_encoder_pkg::RM_K-1:0] info);
    logic [15:0] acc;
    acc = '0;
    for (int r = 0; r < error_encoder_pkg::RM_K; r++) begin
      if (info[r]) begin
        acc = acc ^ RM_ROWS[r];
      end
    end
    return acc;
  endfunction

  // Type-2 bit number idx+1: info, parity, then tail zeros
  function automatic logic type2_bit(input error_encoder_pkg::block_t b,
                                     input logic [IW-1:0] idx,
                                     input logic [IW-1:0] klen,
                                     input logic [15:0] rem);
    logic [IW-1:0] pofs;
    logic [3:0]    pidx;
    logic [15:0]   rm;
    pofs = idx - klen;
    pidx = 4'hF - pofs[3:0];
    rm   = rm_parity(b.data[error_encoder_pkg::RM_K-1:0]);
    if (idx < klen) begin
      return b.data[idx[8:0]];
    end else if (pofs < IW'(16) && b.cfg.code == error_encoder_pkg::CODE_CRC) begin
      return ~rem[pidx];
    end else if (pofs < IW'(16) && b.cfg.code == error_encoder_pkg::CODE_RM) begin
      return rm[pidx];
    end
    return 1'b0;
  endfunction

  // Lengths derived from the held block configuration
  always_comb begin
    k1 = (blk.cfg.code == error_encoder_pkg::CODE_RM) ?
         IW'(error_encoder_pkg::RM_K) : IW'(blk.len);
    k2_len = k1;
    if (blk.cfg.code != error_encoder_pkg::CODE_NONE) begin
      k2_len = k2_len + IW'(error_encoder_pkg::CRC_LEN);
    end
    if (blk.cfg.tail_en) begin
      k2_len = k2_len + IW'(error_encoder_pkg::TAIL_LEN);
    end
    mask   = 8'h01;
    period = '0;
    k3_len = CW'(k2_len);
    case (blk.cfg.rate)
      error_encoder_pkg::RATE_2_3: begin
        mask   = error_encoder_pkg::MASK_2_3;
        k3_len = CW'((CW'(k2_len) * CW'(3)) >> 1);
      end
      error_encoder_pkg::RATE_1_3: begin
        mask   = error_encoder_pkg::MASK_1_3;
        k3_len = CW'(k2_len) * CW'(3);
      end
      error_encoder_pkg::RATE_292_432: begin
        mask   = error_encoder_pkg::MASK_2_3;
        period = error_encoder_pkg::SKIP_292;
        k3_len = error_encoder_pkg::K3_LONG;
      end
      error_encoder_pkg::RATE_148_432: begin
        mask   = error_encoder_pkg::MASK_1_3;
        period = error_encoder_pkg::SKIP_148;
        k3_len = error_encoder_pkg::K3_LONG;
      end
      default: begin
        mask   = 8'h01;
        period = '0;
      end
    endcase
  end

  // Mother code bit, puncturing selection and index gaps
  always_comb begin
    coded = (blk.cfg.rate != error_encoder_pkg::RATE_UNCODED);
    cur   = type2_bit(blk, k2, k1, crc);
    mbit  = coded ? ^(error_encoder_pkg::GEN_TAPS[g] & {sr, cur}) : cur;
    sel   = coded ? mask[{k2[0], g}] : 1'b1;
    skip  = sel && (period != '0) && (skip_cnt == period);
    emit  = (state == error_encoder_pkg::ST_ENC) && sel && !skip;
  end

  // Output word pushed into the FIFO
  always_comb begin
    push_data.value = mbit;
    push_data.last  = (nout == k3_len - 1'b1);
    push_data.kind  = blk.cfg.kind;
  end

  // Sequencer: accept, cyclic remainder pass, serial encode
  always_comb begin
    next_state    = state;
    next_blk      = blk;
    next_crc      = crc;
    next_sr       = sr;
    next_k2       = k2;
    next_g        = g;
    next_nout     = nout;
    next_skip_cnt = skip_cnt;
    case (state)
      error_encoder_pkg::ST_IDLE: begin
        if (blk_valid_in) begin
          next_blk      = blk_in;
          next_crc      = error_encoder_pkg::CRC_PRESET;
          next_sr       = '0;
          next_k2       = '0;
          next_g        = '0;
          next_nout     = '0;
          next_skip_cnt = 7'h01;
          next_state    = (blk_in.cfg.code == error_encoder_pkg::CODE_CRC) ?
                          error_encoder_pkg::ST_CRC : error_encoder_pkg::ST_ENC;
        end
      end
      error_encoder_pkg::ST_CRC: begin
        if (k2 == k1) begin
          next_k2    = '0;
          next_state = error_encoder_pkg::ST_ENC;
        end else begin
          next_crc = {crc[14:0], 1'b0} ^
                     ((crc[15] ^ blk.data[k2[8:0]]) ?
                      error_encoder_pkg::CRC_POLY : 16'h0000);
          next_k2  = k2 + 1'b1;
        end
      end
      error_encoder_pkg::ST_ENC: begin
        if (!emit || push_ready) begin
          if (sel && period != '0) begin
            next_skip_cnt = (skip_cnt == period) ? 7'h01 : skip_cnt + 1'b1;
          end
          if (coded && g != 2'h3) begin
            next_g = g + 1'b1;
          end else begin
            next_g  = '0;
            next_k2 = k2 + 1'b1;
            next_sr = {sr[2:0], cur};
          end
          if (emit) begin
            next_nout = nout + 1'b1;
          end
          if ((emit && push_data.last) ||
              (next_k2 == k2_len && next_g == '0)) begin
            next_state = error_encoder_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        next_state = error_encoder_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state    <= error_encoder_pkg::ST_IDLE;
      blk      <= '0;
      crc      <= error_encoder_pkg::CRC_PRESET;
      sr       <= '0;
      k2       <= '0;
      g        <= '0;
      nout     <= '0;
      skip_cnt <= 7'h01;
    end else begin
      state    <= next_state;
      blk      <= next_blk;
      crc      <= next_crc;
      sr       <= next_sr;
      k2       <= next_k2;
      g        <= next_g;
      nout     <= next_nout;
      skip_cnt <= next_skip_cnt;
    end
  end

  // Handshake and status outputs
  assign blk_ready_out = (state == error_encoder_pkg::ST_IDLE);
  assign busy_out      = (state != error_encoder_pkg::ST_IDLE);

  // Output buffer; a stalled consumer stalls the encoder
  coded_bit_fifo #(
    .WIDTH ($bits(error_encoder_pkg::coded_bit_t)),
    .DEPTH (error_encoder_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_in       (clk_in),
    .sys_rst_in   (sys_rst_in),
    .wr_valid_in  (emit),
    .wr_data_in   (push_data),
    .wr_ready_out (push_ready),
    .rd_valid_out (bit_valid_out),
    .rd_data_out  (bit_out),
    .rd_ready_in  (bit_ready_in)
  );
endmodule

// File: verification/encoder_monitor.sv
// Port checker for the channel error encoder.
// Assumes one clock, synchronous active-high reset; bound at the foot.
`timescale 1ns/1ps
module encoder_monitor (
  // Clock and reset
  input wire logic                          clk_in,
  input wire logic                          sys_rst_in,
  // Block side
  input wire logic                          blk_valid_in,
  input wire error_encoder_pkg::block_t     blk_in,
  input wire logic                          blk_ready_out,
  // Bit side and status
  input wire logic                          bit_valid_out,
  input wire error_encoder_pkg::coded_bit_t bit_out,
  input wire logic                          bit_ready_in,
  input wire logic                          busy_out
);
  default clocking mon_clk @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // Block taken while nothing waits in the FIFO
  sequence acc_s;
    blk_valid_in && blk_ready_out && !bit_valid_out;
  endsequence
  // Checks
  chk_reset_idle: assert property (disable iff (1'b0) sys_rst_in |=>
    blk_ready_out && !busy_out && !bit_valid_out) else $error("not idle after reset");
  chk_ready_busy: assert property (blk_ready_out == !busy_out)
    else $error("ready and busy disagree");
  chk_accept_busy: assert property (blk_valid_in && blk_ready_out |=>
    busy_out && !blk_ready_out) else $error("block accept not followed by busy");
  chk_out_stable: assert property (bit_valid_out && !bit_ready_in |=>
    bit_valid_out && $stable(bit_out)) else $error("stalled bit changed");
  chk_kind_legal: assert property (bit_valid_out |->
    bit_out.kind <= error_encoder_pkg::KIND_HALF2) else $error("bad block kind");
  chk_kind_steady: assert property (bit_valid_out && bit_ready_in && !bit_out.last |=>
    !bit_valid_out || bit_out.kind == $past(bit_out.kind)) else $error("kind changed");
  chk_crc_first: assert property (acc_s ##0
    (blk_in.cfg.code == error_encoder_pkg::CODE_CRC) |=> !bit_valid_out [*3])
    else $error("bit before remainder done");
  chk_plain_first: assert property (acc_s ##0 (blk_in.len != 0 &&
    blk_in.cfg.code == error_encoder_pkg::CODE_NONE &&
    blk_in.cfg.rate == error_encoder_pkg::RATE_UNCODED) |-> ##2 bit_valid_out &&
    bit_out.value == $past(blk_in.data[0], 2)) else $error("first plain bit wrong");
endmodule

bind channel_error_encoder encoder_monitor i_encoder_monitor (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .blk_valid_in(blk_valid_in),
  .blk_in(blk_in), .blk_ready_out(blk_ready_out), .bit_valid_out(bit_valid_out),
  .bit_out(bit_out), .bit_ready_in(bit_ready_in), .busy_out(busy_out));

// File: verification/bit_sink_model.sv
// Downstream stage model: takes coded bits, stalls in bursts on request.
// Assumes the bench watches the bit handshake itself.
`timescale 1ns/1ps
module bit_sink_model (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  // Stall control and handshake
  input  wire logic stall_en_in,
  output logic      bit_ready_out
);
  logic [3:0] phase;
  logic [3:0] next_phase;
  // Free-running stall phase
  always_comb begin
    next_phase = phase + 4'h1;
  end
  always_ff @(posedge clk_in) begin
    phase <= sys_rst_in ? 4'h0 : next_phase;
  end
  // Ready low 8 of 16 cycles when stalling, long enough to fill the FIFO
  assign bit_ready_out = !(stall_en_in && phase[3]);
endmodule

// File: verification/tb_top.sv
// Self-checking bench for the channel error encoder and a bit sink.
// Assumes the package is compiled first; expectations come from expect_block.
`timescale 1ns/1ps
module tb_top;
  logic                          clk_in = 1'b0;
  logic                          sys_rst_in = 1'b1;
  logic                          blk_valid = 1'b0;
  logic                          stall_en = 1'b0;
  logic                          blk_ready;
  logic                          bit_valid;
  logic                          bit_ready;
  logic                          busy;
  error_encoder_pkg::block_t     blk = '0;
  error_encoder_pkg::coded_bit_t bit_o;
  error_encoder_pkg::coded_bit_t e;
  error_encoder_pkg::coded_bit_t exp_q[$];
  int                            fails = 0;
  int                            cmp_count = 0;
  // Code, tail, rate, kind per entry, with type-1 lengths
  logic [8:0] cfgs [7] = '{9'h0CA, 9'h05B, 9'h0E4, 9'h0D0, 9'h101, 9'h000, 9'h109};
  int         lens [7] = '{60, 288, 128, 1, 14, 1, 14};
  // Nonzero parity rows so the RM parity path is really exercised
  localparam logic [13:0][15:0] RM_TEST = {16'h8E3A, 16'h4C15, 16'h2B97, 16'h1D60, 16'hA4F2,
    16'h5319, 16'hC07E, 16'h6A8D, 16'h39B4, 16'hF251, 16'h07CE, 16'hB6A3, 16'h7D08, 16'hE94F};

  always #5 clk_in = ~clk_in;

  channel_error_encoder #(
    .RM_ROWS(RM_TEST)
  ) i_channel_error_encoder (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .blk_valid_in(blk_valid), .blk_in(blk),
    .blk_ready_out(blk_ready), .bit_valid_out(bit_valid), .bit_out(bit_o),
    .bit_ready_in(bit_ready), .busy_out(busy));
  bit_sink_model i_bit_sink_model (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .stall_en_in(stall_en),
    .bit_ready_out(bit_ready));

  // Comparisons
  task automatic cmp_bit(input string name, input logic x, input logic g);
    cmp_count++;
    if (g !== x) begin
      fails++;
      $display("unexpected %s exp %b got %b", name, x, g);
    end
  endtask
  task automatic cmp_kind(input string name, input logic [2:0] x, input logic [2:0] g);
    cmp_count++;
    if (g !== x) begin
      fails++;
      $display("unexpected %s exp %0d got %0d", name, x, g);
    end
  endtask

  // Expected coded stream of one block, appended to the queue
  function automatic void expect_block(input error_encoder_pkg::block_t b);
    logic t2[$];
    logic v[$];
    logic o[$];
    logic [15:0] r;
    logic [15:0] par;
    logic [4:0] h;
    int n, k3, t, i, k;
    int p[6];
    n = (b.cfg.code == error_encoder_pkg::CODE_RM) ? 14 : int'(b.len);
    r = 16'hFFFF;
    par = 16'h0000;
    h = 5'h00;
    for (int j = 0; j < n; j++) begin
      t2.push_back(b.data[j]);
      r = {r[14:0], 1'b0} ^ ((b.data[j] ^ r[15]) ? 16'h1021 : 16'h0000);
      par ^= b.data[j] ? RM_TEST[j] : 16'h0000;
    end
    if (b.cfg.code == error_encoder_pkg::CODE_CRC) r = ~r;
    if (b.cfg.code == error_encoder_pkg::CODE_RM) r = par;
    if (b.cfg.code != error_encoder_pkg::CODE_NONE)
      for (int j = 15; j >= 0; j--) t2.push_back(r[j]);
    if (b.cfg.tail_en) for (int j = 0; j < 4; j++) t2.push_back(1'b0);
    // Mother code, generator one first
    foreach (t2[j]) begin
      h = {h[3:0], t2[j]};
      v.push_back(h[0] ^ h[1] ^ h[4]);
      v.push_back(h[0] ^ h[2] ^ h[3] ^ h[4]);
      v.push_back(h[0] ^ h[1] ^ h[2] ^ h[4]);
      v.push_back(h[0] ^ h[1] ^ h[3] ^ h[4]);
    end
    t = 6;
    p = '{1, 2, 3, 5, 6, 7};
    if (b.cfg.rate inside {error_encoder_pkg::RATE_2_3, error_encoder_pkg::RATE_292_432}) begin
      t = 3;
      p = '{1, 2, 5, 0, 0, 0};
    end
    case (b.cfg.rate)
      error_encoder_pkg::RATE_UNCODED: k3 = 0;
      error_encoder_pkg::RATE_2_3: k3 = t2.size() * 3 / 2;
      error_encoder_pkg::RATE_1_3: k3 = t2.size() * 3;
      default: k3 = 432;
    endcase
    if (k3 == 0) o = t2;
    // Puncturing over periods of eight mother bits
    for (int j = 1; j <= k3; j++) begin
      i = j;
      if (b.cfg.rate == error_encoder_pkg::RATE_292_432) i = j + (j - 1) / 65;
      if (b.cfg.rate == error_encoder_pkg::RATE_148_432) i = j + (j - 1) / 35;
      k = 8 * ((i - 1) / t) + p[(i - 1) % t];
      o.push_back(v[k - 1]);
    end
    foreach (o[j]) exp_q.push_back('{o[j], j == o.size() - 1, b.cfg.kind});
  endfunction

  // Offer one block, hold until taken, then release
  task automatic send(input error_encoder_pkg::block_t b);
    @(posedge clk_in);
    blk_valid <= 1'b1;
    blk <= b;
    do @(posedge clk_in); while (blk_ready !== 1'b1);
    blk_valid <= 1'b0;
    blk <= ~b;
    expect_block(b);
  endtask

  // Wait until all expected bits arrived and the encoder is idle
  task automatic drain();
    int n;
    n = 0;
    while ((exp_q.size() != 0 || busy !== 1'b0) && n < 5000) begin
      @(posedge clk_in);
      n++;
    end
    cmp_bit("drain done", 1'b1, n < 5000);
    cmp_bit("ready when idle", 1'b1, blk_ready);
  endtask

  task automatic finish_test();
    if (fails == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Every bit taken by the sink against the expected stream
  always @(posedge clk_in) begin
    if (!sys_rst_in && bit_valid === 1'b1 && bit_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        cmp_bit("surplus bit", 1'b0, 1'b1);
      end else begin
        e = exp_q.pop_front();
        cmp_bit("bit value", e.value, bit_o.value);
        cmp_bit("last flag", e.last, bit_o.last);
        cmp_kind("block kind", e.kind, bit_o.kind);
      end
    end
  end

  // Table of channels, back to back, then stalled, then one at a time
  initial begin
    error_encoder_pkg::block_t b;
    void'($urandom(32'h358E));
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    for (int pass = 0; pass < 3; pass++) begin
      stall_en <= (pass == 1);
      foreach (cfgs[c]) begin
        b.cfg = error_encoder_pkg::cfg_t'(cfgs[c]);
        b.len = 9'(lens[c]);
        if (c == 3 && pass > 0) b.len = 9'h001 + 9'($urandom % 40);
        for (int w = 0; w < 9; w++) b.data[w * 32 +: 32] = $urandom;
        send(b);
        if (pass == 2) drain();
      end
    end
    drain();
    finish_test();
  end

  // Watchdog
  initial begin
    #400000;
    fails++;
    finish_test();
  end
endmodule
